// File: src/dcb_top.sv
// Data cache front end: load pairing, miss tracking, prefetch hold and
// write combining. Assumes the pipeline presents loads oldest first and
// holds a request until it is accepted.
// What this block does
// RULE1: The cache has eight banks of eight bytes, picked by a bank field.
// RULE2: Two loads conflict only on the same bank with different indexes.
// RULE3: A conflict-free pair issues both loads in a cycle, a conflict issues one.
// RULE4: Loads reach the cache strictly in program order.
// RULE5: At most eight outstanding line requests are held, prefetches included.
// RULE6: Requests to one line share one tracking entry and count once.
// RULE7: A prefetch matching a pending store line waits until that store is written.
// RULE8: Writes of any size into the same 64-byte line merge into one write buffer.
// RULE9: The line of 64 bytes is the unit of fills, prefetches and tracking.
// RULE10: A fetch hint requests the whole line and updates only the cache.
// RULE11: A modify-intent hint installs its line in the modified state.
// RULE12: With the tracker full the next read to an untracked line stalls until an entry frees, in order.
// RULE13: Bank is address bits five to three, index is the bits above the line offset.
// RULE14: On a conflict the older load goes now and the younger one next cycle.
`timescale 1ns/1ns
`default_nettype none
module dcb_top
   import dcb_pkg::*;
(
   // Clock and reset
   input  wire logic                  i_sys_clk,
   input  wire logic                  i_rst_n,
   // Load pair from pipeline, slot 0 older
   input  wire logic                  i_ld0_valid,
   input  wire logic [ADDR_W-1:0]     i_ld0_addr,
   input  wire logic                  i_ld1_valid,
   input  wire logic [ADDR_W-1:0]     i_ld1_addr,
   output logic                       o_ld0_accept,
   output logic                       o_ld1_accept,
   // Load issue to cache banks
   output logic                       o_bank_rd0_valid,
   output logic [ADDR_W-1:0]          o_bank_rd0_addr,
   output logic                       o_bank_rd1_valid,
   output logic [ADDR_W-1:0]          o_bank_rd1_addr,
   output logic [NUM_BANKS-1:0]       o_bank_sel,
   output logic                       o_conflict,
   // Miss and prefetch requests
   input  wire logic                  i_rd_valid,
   input  wire logic [ADDR_W-1:0]     i_rd_addr,
   input  wire logic                  i_rd_prefetch,
   input  wire logic                  i_rd_modify,
   output logic                       o_rd_accept,
   output logic                       o_mem_req_valid,
   output logic [LINE_W-1:0]          o_mem_req_line,
   output logic [TRK_W-1:0]           o_mem_req_tag,
   output logic                       o_mem_req_modify,
   output logic                       o_mem_req_prefetch,
   input  wire logic                  i_mem_fill_valid,
   input  wire logic [TRK_W-1:0]      i_mem_fill_tag,
   output logic                       o_fill_install,
   output logic [LINE_W-1:0]          o_fill_line,
   output logic                       o_fill_modified,
   output logic [NUM_TRK-1:0]         o_trk_busy,
   // Pending store address and cache write done
   input  wire logic                  i_st_pend_valid,
   input  wire logic [ADDR_W-1:0]     i_st_pend_addr,
   // Combining writes
   input  wire logic                  i_wr_valid,
   input  wire logic [ADDR_W-1:0]     i_wr_addr,
   input  wire logic [BANK_BYTES-1:0] i_wr_be,
   input  wire logic [BANK_BYTES*8-1:0] i_wr_data,
   input  wire logic                  i_wr_flush,
   output logic                       o_wr_accept,
   output logic                       o_wb_valid,
   output logic [LINE_W-1:0]          o_wb_line,
   output logic [LINE_BYTES-1:0]      o_wb_be,
   output logic [WB_DATA_W-1:0]       o_wb_data,
   input  wire logic                  i_wb_ready
);
   // ********************************************************************
   // Load pairing
   // ********************************************************************
   // RULE13 address fields
   wire [BANK_HI-BANK_LO:0] bank0 = i_ld0_addr[BANK_HI:BANK_LO];
   wire [BANK_HI-BANK_LO:0] bank1 = i_ld1_addr[BANK_HI:BANK_LO];
   wire [IDX_W-1:0]         idx0  = i_ld0_addr[ADDR_W-1:OFFS_W];
   wire [IDX_W-1:0]         idx1  = i_ld1_addr[ADDR_W-1:OFFS_W];
   // RULE2 conflict test
   wire conflict = i_ld0_valid && i_ld1_valid && (bank0 == bank1) && (idx0 != idx1);
   // RULE3 dual issue
   // RULE4 in order
   // RULE14 younger retried
   wire iss0 = i_ld0_valid;
   wire iss1 = i_ld0_valid && i_ld1_valid && !conflict;
   logic [NUM_BANKS-1:0] sel_d;

   // RULE1 bank select
   always_comb begin
      sel_d = '0;
      if (iss0) begin
         sel_d[bank0] = 1'b1;
      end
      if (iss1) begin
         sel_d[bank1] = 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_ld0_accept     <= 1'b0;
         o_ld1_accept     <= 1'b0;
         o_bank_rd0_valid <= 1'b0;
         o_bank_rd1_valid <= 1'b0;
         o_bank_rd0_addr  <= '0;
         o_bank_rd1_addr  <= '0;
         o_bank_sel       <= '0;
         o_conflict       <= 1'b0;
      end else begin
         o_ld0_accept     <= iss0;
         o_ld1_accept     <= iss1;
         o_bank_rd0_valid <= iss0;
         o_bank_rd1_valid <= iss1;
         o_bank_rd0_addr  <= i_ld0_addr;
         o_bank_rd1_addr  <= i_ld1_addr;
         o_bank_sel       <= sel_d;
         o_conflict       <= conflict;
      end
   end

   // ********************************************************************
   // Miss tracking
   // ********************************************************************
   dcb_trk_if trk_bus ();

   dcb_trk u_trk (
      .i_sys_clk (i_sys_clk),
      .i_rst_n   (i_rst_n),
      .trk       (trk_bus.lookup)
   );

   // RULE9 line granularity
   wire [LINE_W-1:0] rd_line = i_rd_addr[ADDR_W-1:OFFS_W];
   // RULE7 prefetch hold
   wire pf_hold = i_rd_prefetch && i_st_pend_valid &&
                  (i_st_pend_addr[ADDR_W-1:OFFS_W] == rd_line);
   // RULE12 stall when full
   wire rd_take = i_rd_valid && !pf_hold && (trk_bus.req_hit || !trk_bus.req_full);
   wire rd_new  = rd_take && !trk_bus.req_hit;
   logic [NUM_TRK-1:0] mod_q;

   assign trk_bus.req_line   = rd_line;
   assign trk_bus.req_valid  = i_rd_valid && !pf_hold;
   assign trk_bus.fill_valid = i_mem_fill_valid;
   assign trk_bus.fill_slot  = i_mem_fill_tag;

   // RULE11 modify intent kept
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mod_q <= TRK_RST;
      end else if (rd_take && i_rd_modify) begin
         mod_q[trk_bus.req_slot] <= 1'b1;
      end else if (rd_new) begin
         mod_q[trk_bus.req_slot] <= 1'b0;
      end
   end

   logic [LINE_W-1:0] fill_line_q [NUM_TRK];
   always_ff @(posedge i_sys_clk) begin
      if (rd_new) begin
         fill_line_q[trk_bus.req_slot] <= rd_line;
      end
   end

   // RULE10 whole line fill
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rd_accept        <= 1'b0;
         o_mem_req_valid    <= 1'b0;
         o_mem_req_line     <= '0;
         o_mem_req_tag      <= '0;
         o_mem_req_modify   <= 1'b0;
         o_mem_req_prefetch <= 1'b0;
         o_fill_install     <= 1'b0;
         o_fill_line        <= '0;
         o_fill_modified    <= 1'b0;
         o_trk_busy         <= '0;
      end else begin
         o_rd_accept        <= rd_take;
         o_mem_req_valid    <= rd_new;
         o_mem_req_line     <= rd_line;
         o_mem_req_tag      <= trk_bus.req_slot;
         o_mem_req_modify   <= i_rd_modify;
         o_mem_req_prefetch <= i_rd_prefetch;
         o_fill_install     <= i_mem_fill_valid && trk_bus.busy[i_mem_fill_tag];
         o_fill_line        <= fill_line_q[i_mem_fill_tag];
         o_fill_modified    <= mod_q[i_mem_fill_tag];
         o_trk_busy         <= trk_bus.busy;
      end
   end

   // ********************************************************************
   // Write combining
   // ********************************************************************
   dcb_wb_state_e wb_q;
   wire [LINE_W-1:0] wr_line = i_wr_addr[ADDR_W-1:OFFS_W];
   wire [OFFS_W-BANK_LO-1:0] wr_word = i_wr_addr[BANK_HI:BANK_LO];
   // RULE8 same line merges
   wire wr_merge = i_wr_valid && (wb_q == DCB_WB_OPEN) && (wr_line == o_wb_line);
   wire wr_open  = i_wr_valid && (wb_q == DCB_WB_IDLE);
   wire flush_or_miss = i_wr_flush || (i_wr_valid && wr_line != o_wb_line);
   wire wr_other = (wb_q == DCB_WB_OPEN) && flush_or_miss;
   wire wb_done  = (wb_q == DCB_WB_FLUSH) && i_wb_ready;

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wb_q        <= DCB_WB_IDLE;
         o_wb_valid  <= 1'b0;
         o_wb_line   <= '0;
         o_wb_be     <= '0;
         o_wb_data   <= '0;
         o_wr_accept <= 1'b0;
      end else begin
         o_wr_accept <= wr_open || wr_merge;
         case (wb_q)
            DCB_WB_IDLE: begin
               if (wr_open) begin
                  wb_q      <= DCB_WB_OPEN;
                  o_wb_line <= wr_line;
                  o_wb_be   <= '0;
               end
            end
            DCB_WB_OPEN: begin
               if (wr_other) begin
                  wb_q       <= DCB_WB_FLUSH;
                  o_wb_valid <= 1'b1;
               end
            end
            DCB_WB_FLUSH: begin
               if (wb_done) begin
                  wb_q       <= DCB_WB_IDLE;
                  o_wb_valid <= 1'b0;
               end
            end
            default: wb_q <= DCB_WB_IDLE;
         endcase
         if (wr_open || wr_merge) begin
            for (int b = 0; b < BANK_BYTES; b++) begin
               if (i_wr_be[b]) begin
                  o_wb_be[wr_word*BANK_BYTES+b]          <= 1'b1;
                  o_wb_data[(wr_word*BANK_BYTES+b)*8 +: 8] <= i_wr_data[b*8 +: 8];
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

// File: src/dcb_pkg.sv
// Shared constants and types for the data cache bank and miss tracker.
// Assumes one clock domain and physical byte addresses of fixed width.
package dcb_pkg;
   // ********************************************************************
   // Address layout
   // ********************************************************************
   localparam int ADDR_W      = 32;
   localparam int LINE_BYTES  = 64;
   localparam int OFFS_W      = 6;
   localparam int BANK_LO     = 3;
   localparam int BANK_HI     = 5;
   localparam int NUM_BANKS   = 8;
   localparam int BANK_BYTES  = 8;
   localparam int LINE_W      = ADDR_W - OFFS_W;
   localparam int IDX_W       = LINE_W;
   // ********************************************************************
   // Tracking and buffers
   // ********************************************************************
   localparam int NUM_TRK     = 8;
   localparam int TRK_W       = 3;
   localparam int WB_DATA_W   = LINE_BYTES * 8;
   localparam logic [NUM_TRK-1:0] TRK_RST = 8'h00;

   typedef enum logic [2:0] {
      DCB_WB_IDLE  = 3'b001,
      DCB_WB_OPEN  = 3'b010,
      DCB_WB_FLUSH = 3'b100
   } dcb_wb_state_e;
endpackage

// File: src/dcb_trk_if.sv
// Interface carrying lookups from the main block to the line tracker.
// Assumes a single clock shared by both ends.
`timescale 1ns/1ns
`default_nettype none
interface dcb_trk_if;
   import dcb_pkg::*;
   logic [LINE_W-1:0] req_line;
   logic              req_valid;
   logic              req_hit;
   logic              req_full;
   logic [TRK_W-1:0]  req_slot;
   logic              fill_valid;
   logic [TRK_W-1:0]  fill_slot;
   logic [NUM_TRK-1:0] busy;
   modport owner (output req_line, req_valid, fill_valid, fill_slot,
                  input req_hit, req_full, req_slot, busy);
   modport lookup (input req_line, req_valid, fill_valid, fill_slot,
                  output req_hit, req_full, req_slot, busy);
endinterface
`default_nettype wire

// File: src/dcb_trk.sv
// Outstanding line tracker: eight entries, one per distinct cache line.
// Assumes the owner only allocates when not full and frees busy slots.
`timescale 1ns/1ns
`default_nettype none
module dcb_trk
   import dcb_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   dcb_trk_if.lookup trk
);
   logic [NUM_TRK-1:0] vld_q;
   logic [LINE_W-1:0]  line_q [NUM_TRK];
   logic [NUM_TRK-1:0] match;
   logic [NUM_TRK-1:0] free_onehot;
   logic [TRK_W-1:0]   hit_slot;
   logic [TRK_W-1:0]   free_slot;
   wire                alloc = trk.req_valid && !trk.req_hit && !trk.req_full;

   // ********************************************************************
   // Per entry match and storage
   // ********************************************************************
   genvar g;
   generate
      for (g = 0; g < NUM_TRK; g++) begin : g_ent
         // RULE6 same line shares
         assign match[g] = vld_q[g] && (line_q[g] == trk.req_line);
         if (g == 0) begin : g_low
            assign free_onehot[g] = !vld_q[g];
         end else begin : g_up
            assign free_onehot[g] = !vld_q[g] && (&vld_q[g-1:0]);
         end
         always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               vld_q[g] <= 1'b0;
            end else if (alloc && free_onehot[g]) begin
               vld_q[g] <= 1'b1;
            end else if (trk.fill_valid && trk.fill_slot == TRK_W'(g)) begin
               vld_q[g] <= 1'b0;
            end
         end
         always_ff @(posedge i_sys_clk) begin
            if (alloc && free_onehot[g]) begin
               line_q[g] <= trk.req_line;
            end
         end
      end
   endgenerate

   always_comb begin
      hit_slot  = '0;
      free_slot = '0;
      for (int k = 0; k < NUM_TRK; k++) begin
         if (match[k]) begin
            hit_slot = TRK_W'(k);
         end
         if (free_onehot[k]) begin
            free_slot = TRK_W'(k);
         end
      end
   end

   // RULE5 eight entry limit
   assign trk.req_full = &vld_q;
   assign trk.req_hit  = |match;
   assign trk.req_slot = trk.req_hit ? hit_slot : free_slot;
   assign trk.busy     = vld_q;
endmodule
`default_nettype wire

// File: test/dcb_mem_model.sv
// Memory side model: answers each new line request with one fill.
// Assumes tags come from the block's request port; i_hold stalls fills.
`timescale 1ns/1ns
`default_nettype none
module dcb_mem_model
   import dcb_pkg::*;
#(
   parameter int LAT = 3
)
(
   // Clock, reset and stall
   input  wire logic             i_sys_clk,
   input  wire logic             i_rst_n,
   input  wire logic             i_hold,
   // Request in, fill out
   input  wire logic             i_req_valid,
   input  wire logic [TRK_W-1:0] i_req_tag,
   output logic                  o_fill_valid,
   output logic [TRK_W-1:0]      o_fill_tag
);
   logic [TRK_W-1:0] pend[$];
   int               wait_n;
   always @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pend = {};
         wait_n = 0;
         o_fill_valid <= 1'b0;
         o_fill_tag <= '0;
      end else begin
         if (i_req_valid) pend.push_back(i_req_tag);
         o_fill_valid <= 1'b0;
         // Idle tag toggles so a stale value is never mistaken for a fill
         o_fill_tag <= ~o_fill_tag;
         if (pend.size() > 0 && !i_hold) begin
            if (wait_n == LAT) begin
               o_fill_valid <= 1'b1;
               o_fill_tag <= pend.pop_front();
               wait_n = 0;
            end else begin
               wait_n++;
            end
         end
      end
   end
endmodule
`default_nettype wire

// File: test/dcb_top_sva.sv
// Checker for the data cache front end, bound to the top module.
// Assumes a single clock and active-low asynchronous reset.
`timescale 1ns/1ns
`default_nettype none
module dcb_top_sva
   import dcb_pkg::*;
(
   input wire logic i_sys_clk, i_rst_n, i_ld0_valid, i_ld1_valid,
   input wire logic [ADDR_W-1:0] i_ld0_addr, i_ld1_addr, i_rd_addr, i_st_pend_addr,
   input wire logic o_ld0_accept, o_ld1_accept, o_conflict, o_rd_accept,
   input wire logic [ADDR_W-1:0] o_bank_rd0_addr,
   input wire logic [NUM_BANKS-1:0] o_bank_sel,
   input wire logic i_rd_valid, i_rd_prefetch, o_mem_req_valid, i_mem_fill_valid,
   input wire logic [LINE_W-1:0] o_mem_req_line, o_wb_line,
   input wire logic [TRK_W-1:0] o_mem_req_tag,
   input wire logic [NUM_TRK-1:0] o_trk_busy,
   input wire logic i_st_pend_valid, o_wb_valid, i_wb_ready
);
   // *****
   // Properties
   // *****
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   wire same_bank = i_ld0_addr[5:3] == i_ld1_addr[5:3];
   wire diff_idx  = i_ld0_addr[31:6] != i_ld1_addr[31:6];
   wire both_ld   = i_ld0_valid && i_ld1_valid;
   a_pair_conflict: assert property (both_ld && same_bank && diff_idx |=>
      o_conflict && o_ld0_accept && !o_ld1_accept) else $error("conflict pair wrong");
   a_pair_dual: assert property (both_ld && !(same_bank && diff_idx) |=>
      o_ld1_accept && !o_conflict) else $error("pair not dual issued");
   a_order_keep: assert property (!i_ld0_valid |=> !o_ld0_accept && !o_ld1_accept)
      else $error("load issued out of order");
   a_bank_sel: assert property (o_ld0_accept |-> o_bank_sel[o_bank_rd0_addr[5:3]])
      else $error("bank select wrong");
   a_req_busy: assert property (o_mem_req_valid |=> o_trk_busy[$past(o_mem_req_tag)])
      else $error("request tag not busy");
   a_req_line: assert property (o_mem_req_valid |->
      o_rd_accept && o_mem_req_line == $past(i_rd_addr[31:6])) else $error("line wrong");
   a_pf_hold: assert property (i_rd_valid && i_rd_prefetch && i_st_pend_valid &&
      i_rd_addr[31:6] == i_st_pend_addr[31:6] |=> !o_rd_accept) else $error("prefetch not held");
   a_full_stall: assert property (i_rd_valid && &o_trk_busy && !i_mem_fill_valid
      && !$past(i_mem_fill_valid) |=> !o_mem_req_valid) else $error("request past full tracker");
   a_wb_hold: assert property (o_wb_valid && !i_wb_ready |=>
      o_wb_valid && $stable(o_wb_line)) else $error("write buffer dropped");
   c_conflict: cover property (o_conflict);
   c_full: cover property (&o_trk_busy);
   c_wb: cover property (o_wb_valid && i_wb_ready);
endmodule
`default_nettype wire
bind dcb_top dcb_top_sva i_sva (.*);

// File: test/tb_top.sv
// Self-checking bench for the data cache front end.
// Assumes the memory model answers fills; bench drives the pipeline side.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin failures++; \
   $display("unexpected %s exp %0h got %0h", nm, ex, got); end end
module tb_top;
   import dcb_pkg::*;
   logic i_sys_clk = 0, i_rst_n = 0, i_ld0_valid = 0, i_ld1_valid = 0, i_rd_valid = 0;
   logic i_rd_prefetch = 0, i_rd_modify = 0, i_st_pend_valid = 0, i_wr_valid = 0;
   logic i_wr_flush = 0, i_wb_ready = 0, hold = 1, i_mem_fill_valid;
   logic [31:0] i_ld0_addr = 0, i_ld1_addr = 0, i_rd_addr = 0, i_st_pend_addr = 0;
   logic [31:0] i_wr_addr = 0, o_bank_rd0_addr, o_bank_rd1_addr;
   logic [7:0] i_wr_be = 0, o_bank_sel, o_trk_busy;
   logic [63:0] i_wr_data = 0, o_wb_be;
   logic [2:0] i_mem_fill_tag, o_mem_req_tag;
   logic [25:0] o_mem_req_line, o_fill_line, o_wb_line;
   logic [511:0] o_wb_data;
   logic o_ld0_accept, o_ld1_accept, o_bank_rd0_valid, o_bank_rd1_valid, o_conflict;
   logic o_rd_accept, o_mem_req_valid, o_mem_req_modify, o_mem_req_prefetch;
   logic o_fill_install, o_fill_modified, o_wr_accept, o_wb_valid;
   int failures = 0, n_compared = 0, cycles = 0, n;
   dcb_top i_dut (.*);
   dcb_mem_model i_mem (.i_sys_clk, .i_rst_n, .i_hold(hold), .i_req_valid(o_mem_req_valid),
      .i_req_tag(o_mem_req_tag), .o_fill_valid(i_mem_fill_valid), .o_fill_tag(i_mem_fill_tag));
   initial forever #4 i_sys_clk = ~i_sys_clk;
   always @(posedge i_sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         complete_run();
      end
   end
   // *****
   // Scenario tasks
   // *****
   task automatic ld_pair(input logic [31:0] a0, a1, input logic v1);
      logic cf;
      logic [7:0] sel;
      cf = v1 && a0[5:3] == a1[5:3] && a0[31:6] != a1[31:6];
      sel = (8'h01 << a0[5:3]) | ((v1 && !cf) ? 8'h01 << a1[5:3] : 8'h00);
      @(posedge i_sys_clk);
      {i_ld0_valid, i_ld1_valid, i_ld0_addr, i_ld1_addr} <= {1'b1, v1, a0, a1};
      @(posedge i_sys_clk);
      {i_ld0_valid, i_ld1_valid} <= 2'b00;
      @(negedge i_sys_clk);
      `CHK("ld0_accept", 1'b1, o_ld0_accept)
      `CHK("ld1_accept", v1 && !cf, o_ld1_accept)
      `CHK("conflict", cf, o_conflict)
      `CHK("bank_sel", sel, o_bank_sel)
      `CHK("rd0_valid", 1'b1, o_bank_rd0_valid)
      `CHK("rd0_addr", a0, o_bank_rd0_addr)
      `CHK("rd1_valid", v1 && !cf, o_bank_rd1_valid)
      if (v1) `CHK("rd1_addr", a1, o_bank_rd1_addr)
   endtask
   task automatic rd_pulse(input logic [31:0] a, input logic is_new, input logic [2:0] tag);
      @(posedge i_sys_clk);
      {i_rd_valid, i_rd_addr} <= {1'b1, a};
      @(posedge i_sys_clk);
      i_rd_valid <= 1'b0;
      @(negedge i_sys_clk);
      `CHK("rd_accept", 1'b1, o_rd_accept)
      `CHK("mem_req_valid", is_new, o_mem_req_valid)
      if (is_new) `CHK("mem_req_tag", tag, o_mem_req_tag)
      if (is_new) `CHK("mem_req_line", a[31:6], o_mem_req_line)
   endtask
   task automatic test_tracker();
      for (int i = 0; i < 8; i++) rd_pulse(32'h0001_0000 + 64 * i, 1'b1, 3'(i));
      @(negedge i_sys_clk);
      `CHK("trk_busy", 8'hFF, o_trk_busy)
      rd_pulse(32'h0001_0038, 1'b0, 3'h0);
      @(posedge i_sys_clk);
      {i_rd_valid, i_rd_addr} <= {1'b1, 32'h0002_0000};
      repeat (6) begin
         @(negedge i_sys_clk);
         `CHK("rd_accept full", 1'b0, o_rd_accept)
      end
      @(posedge i_sys_clk);
      hold <= 1'b0;
      for (n = 0; n < 40 && o_rd_accept !== 1'b1; n++) @(negedge i_sys_clk);
      `CHK("mem_req after free", 1'b1, o_mem_req_valid)
      `CHK("freed tag", 3'h0, o_mem_req_tag)
      @(posedge i_sys_clk);
      i_rd_valid <= 1'b0;
      for (n = 0; n < 100 && o_trk_busy !== 8'h00; n++) @(negedge i_sys_clk);
      `CHK("trk drained", 8'h00, o_trk_busy)
   endtask
   task automatic test_prefetch();
      @(posedge i_sys_clk);
      {i_st_pend_valid, i_st_pend_addr} <= {1'b1, 32'h0003_0010};
      {i_rd_valid, i_rd_prefetch, i_rd_modify, i_rd_addr} <= {3'b111, 32'h0003_0020};
      repeat (4) begin
         @(negedge i_sys_clk);
         `CHK("pf held", 1'b0, o_rd_accept)
      end
      @(posedge i_sys_clk);
      i_st_pend_valid <= 1'b0;
      for (n = 0; n < 10 && o_rd_accept !== 1'b1; n++) @(negedge i_sys_clk);
      `CHK("pf modify", 1'b1, o_mem_req_modify)
      `CHK("pf flag", 1'b1, o_mem_req_prefetch)
      @(posedge i_sys_clk);
      {i_rd_valid, i_rd_prefetch, i_rd_modify} <= 3'b000;
      for (n = 0; n < 40 && o_fill_install !== 1'b1; n++) @(negedge i_sys_clk);
      `CHK("fill_line", 26'h000_0C00, o_fill_line)
      `CHK("fill_modified", 1'b1, o_fill_modified)
   endtask
   task automatic wr_one(input logic [31:0] a, input logic [7:0] be);
      @(posedge i_sys_clk);
      {i_wr_valid, i_wr_addr, i_wr_be, i_wr_data} <= {1'b1, a, be, 64'h1122_3344_5566_7788};
      @(posedge i_sys_clk);
      i_wr_valid <= 1'b0;
      @(negedge i_sys_clk);
      `CHK("wr_accept", 1'b1, o_wr_accept)
   endtask
   task automatic test_combine();
      wr_one(32'h1000_0008, 8'h0F);
      wr_one(32'h1000_0030, 8'hFF);
      @(posedge i_sys_clk);
      i_wr_flush <= 1'b1;
      @(posedge i_sys_clk);
      i_wr_flush <= 1'b0;
      repeat (3) @(negedge i_sys_clk);
      `CHK("wb_valid", 1'b1, o_wb_valid)
      `CHK("wb_line", 26'h040_0000, o_wb_line)
      `CHK("wb_be", 64'h00FF_0000_0000_0F00, o_wb_be)
      `CHK("wb_data word6", 64'h1122_3344_5566_7788, o_wb_data[384 +: 64])
      `CHK("wb_data word1", 32'h5566_7788, o_wb_data[64 +: 32])
      @(posedge i_sys_clk);
      i_wb_ready <= 1'b1;
      for (n = 0; n < 10 && o_wb_valid !== 1'b0; n++) @(negedge i_sys_clk);
      `CHK("wb drained", 1'b0, o_wb_valid)
      @(posedge i_sys_clk);
      i_wb_ready <= 1'b0;
   endtask
   task automatic complete_run();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
      ld_pair(32'h0000_1008, 32'h0000_1010, 1'b1);
      ld_pair(32'h0000_1008, 32'h0000_100C, 1'b1);
      ld_pair(32'h0000_1008, 32'h0000_2008, 1'b1);
      ld_pair(32'h0000_2008, 32'h0000_0000, 1'b0);
      test_tracker();
      test_prefetch();
      test_combine();
      complete_run();
   end
endmodule
`default_nettype wire
